// *** logic/mdsf_cfg.svh ***
// constants of the mac/dma status flag bank: bits 18..9 of the status word
// assumes a 125 MHz register clock and the plain strobe register port
// How it works
// - frame_received_flag, bit 18, sets once a frame's receive descriptor is written back
// - rx_desc_empty_flag, bit 17, sets when a fetched descriptor is not DMA-owned
// - rx_fifo_overflow_flag, bit 16, sets when the FIFO overflows during reception
// - bits 15 to 12 read zero; software writes only zero there
// - no_carrier_flag, bit 11, sets if no carrier when transmission starts
// - carrier_lost_flag, bit 10, sets when carrier drops during a frame
// - late_collision_flag, bit 9, sets on a collision late in transmission
// - a flag raises the interrupt only with its enable bit set; enables reset zero
`ifndef MDSF_CFG_SVH
`define MDSF_CFG_SVH

// register port
`define MDSF_ADDR_W         8
`define MDSF_STATUS_OFS     8'h00
`define MDSF_IRQ_EN_OFS     8'h04

// flag positions in the 32-bit status and enable words
`define MDSF_FR_BIT         18
`define MDSF_RDE_BIT        17
`define MDSF_RX_FIFO_OVERFLOW_FLAG_BIT       16
`define MDSF_RSV_HI_BIT     15
`define MDSF_RSV_LO_BIT     12
`define MDSF_CND_BIT        11
`define MDSF_DLC_BIT        10
`define MDSF_LCOL_BIT       9
`define MDSF_NUM_FLAGS      6

// reset values
`define MDSF_FLAGS_RST      6'h00
`define MDSF_IRQ_EN_RST     6'h00
`define MDSF_WORD_RST       32'h0000_0000

// timing: a collision after one slot time counts as late
`define MDSF_CLK_NS         8
`define MDSF_SLOT_NS        5120
`define MDSF_SLOT_CYC       ((`MDSF_SLOT_NS + `MDSF_CLK_NS - 1) / `MDSF_CLK_NS)
`define MDSF_SLOT_CNT_W     10

`endif

// *** logic/mdsf_pkg.sv ***
// types shared by the status flag bank and its sticky bit cell
// assumes mdsf_cfg.svh is on the include path
`include "mdsf_cfg.svh"

package mdsf_pkg;

    // transmit monitor states, one-hot
    typedef enum logic [2:0] {
        MDSF_TX_IDLE  = 3'b001,
        MDSF_TX_EARLY = 3'b010,
        MDSF_TX_LATE  = 3'b100
    } mdsf_tx_state_t;

    // one register access from the cpu side
    typedef struct packed {
        logic [`MDSF_ADDR_W-1:0] addr;
        logic [31:0]             wdata;
        logic                    wr;
        logic                    rd;
    } mdsf_bus_req_t;

    // one-cycle events, msb first matches flag index 5..0
    typedef struct packed {
        logic frame_received;
        logic rx_desc_empty;
        logic rx_fifo_overflow;
        logic no_carrier;
        logic carrier_lost;
        logic late_collision;
    } mdsf_events_t;

    // state of a sticky cell
    typedef struct packed {
        logic flag;
    } mdsf_cell_t;

    // state of the bank top
    typedef struct packed {
        logic [31:0]                 rdata;
        logic                        irq;
        logic [`MDSF_NUM_FLAGS-1:0]  irq_en;
        logic                        rx_stalled;
        logic                        crs_s1;
        logic                        crs_s2;
        logic                        col_s1;
        logic                        col_s2;
        logic                        col_prev;
        logic                        crs_seen;
        mdsf_tx_state_t              tx_state;
        logic [`MDSF_SLOT_CNT_W-1:0] slot_cnt;
    } mdsf_state_t;

endpackage : mdsf_pkg

// *** logic/mdsf_sticky_bit.sv ***
// one sticky status flag: set by a hardware event, cleared by software
// assumes set and clear are single-cycle terms on i_clk
`timescale 1ns/1ps

module mdsf_sticky_bit (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // control
    input  wire logic i_set,
    input  wire logic i_clr,
    // flag
    output logic      o_flag
);

    mdsf_pkg::mdsf_cell_t st;
    mdsf_pkg::mdsf_cell_t next_st;

    always_comb begin
        next_st = st;
        // an event in the clearing cycle must not be lost
        if (i_set) begin
            next_st.flag = 1'b1;
        end else if (i_clr) begin
            next_st.flag = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_flag = st.flag;

endmodule // mdsf_sticky_bit

// *** logic/mdsf_status_flags.sv ***
// status flag bank for bits 18..9 of the mac/dma status word, with its
// interrupt enable register and one level interrupt
// assumes rx dma and tx mac strobes are on i_clk; carrier and collision are
// raw phy pins and are synchronised here
`timescale 1ns/1ps

module mdsf_status_flags (
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // register port
    input  wire mdsf_pkg::mdsf_bus_req_t i_bus,
    output logic [31:0]                 o_rdata,
    // receive dma side
    input  wire logic                   i_rx_desc_written,
    input  wire logic                   i_rx_desc_fetched,
    input  wire logic                   i_rx_desc_owned_bit,
    input  wire logic                   i_rx_frame_busy,
    input  wire logic                   i_rx_fifo_ovf,
    input  wire logic                   i_rx_restart,
    output logic                        o_rx_stalled,
    // transmit mac side
    input  wire logic                   i_tx_start,
    input  wire logic                   i_tx_end,
    // phy pins
    input  wire logic                   i_carrier_sense,
    input  wire logic                   i_collision,
    // interrupt
    output logic                        o_irq
);

    mdsf_pkg::mdsf_state_t  st;
    mdsf_pkg::mdsf_state_t  next_st;
    mdsf_pkg::mdsf_events_t evt;

    logic [`MDSF_NUM_FLAGS-1:0] flags;
    logic [`MDSF_NUM_FLAGS-1:0] flag_set;
    logic [`MDSF_NUM_FLAGS-1:0] flag_clr;
    logic [`MDSF_NUM_FLAGS-1:0] wr_ones;
    logic [`MDSF_NUM_FLAGS-1:0] next_flags_seen;
    logic                       sel_status;
    logic                       sel_irq_en;
    logic                       slot_done;

    // spread the six flags over their places in the 32-bit word
    function automatic logic [31:0] pack_word(input logic [`MDSF_NUM_FLAGS-1:0] v);
        logic [31:0] w;
        w = `MDSF_WORD_RST;
        w[`MDSF_FR_BIT]   = v[5];
        w[`MDSF_RDE_BIT]  = v[4];
        w[`MDSF_RX_FIFO_OVERFLOW_FLAG_BIT] = v[3];
        w[`MDSF_CND_BIT]  = v[2];
        w[`MDSF_DLC_BIT]  = v[1];
        w[`MDSF_LCOL_BIT] = v[0];
        return w;
    endfunction

    // gather the six flags from a written word; other bits are dropped
    function automatic logic [`MDSF_NUM_FLAGS-1:0] unpack_word(input logic [31:0] w);
        logic [`MDSF_NUM_FLAGS-1:0] v;
        v = `MDSF_FLAGS_RST;
        v[5] = w[`MDSF_FR_BIT];
        v[4] = w[`MDSF_RDE_BIT];
        v[3] = w[`MDSF_RX_FIFO_OVERFLOW_FLAG_BIT];
        v[2] = w[`MDSF_CND_BIT];
        v[1] = w[`MDSF_DLC_BIT];
        v[0] = w[`MDSF_LCOL_BIT];
        return v;
    endfunction

    assign sel_status = (i_bus.addr == `MDSF_STATUS_OFS);
    assign sel_irq_en = (i_bus.addr == `MDSF_IRQ_EN_OFS);
    assign wr_ones    = unpack_word(i_bus.wdata);
    assign slot_done  = (st.slot_cnt == `MDSF_SLOT_CNT_W'(`MDSF_SLOT_CYC - 1));

    // receive events come straight from the dma on this clock
    always_comb begin
        evt = '0;
        evt.frame_received   = i_rx_desc_written;
        evt.rx_desc_empty    = i_rx_desc_fetched & ~i_rx_desc_owned_bit;
        evt.rx_fifo_overflow = i_rx_fifo_ovf & i_rx_frame_busy;
        // carrier is sampled at the start strobe; present carrier leaves it low
        evt.no_carrier       = i_tx_start & ~st.crs_s2;
        // a drop only counts once carrier was seen in this frame
        evt.carrier_lost     = (st.tx_state != mdsf_pkg::MDSF_TX_IDLE) & ~i_tx_start
                               & st.crs_seen & ~st.crs_s2;
        // rising collision after the slot time is late
        evt.late_collision   = (st.tx_state == mdsf_pkg::MDSF_TX_LATE) & ~i_tx_start
                               & st.col_s2 & ~st.col_prev;
    end

    assign flag_set = evt;

    // write one clears, and a status read clears what it returned
    always_comb begin
        flag_clr = `MDSF_FLAGS_RST;
        if (i_bus.wr && sel_status) begin
            flag_clr = wr_ones;
        end else if (i_bus.rd && sel_status) begin
            flag_clr = flags;
        end
    end

    // flags as they stand after this edge, for the interrupt path
    assign next_flags_seen = flag_set | (flags & ~flag_clr);

    genvar gi;
    generate
        for (gi = 0; gi < `MDSF_NUM_FLAGS; gi++) begin : g_flag
            mdsf_sticky_bit u_flag (
                .i_clk (i_clk),
                .i_rst (i_rst),
                .i_set (flag_set[gi]),
                .i_clr (flag_clr[gi]),
                .o_flag(flags[gi])
            );
        end
    endgenerate

    always_comb begin
        next_st = st;

        // phy pins: two flops before any use
        next_st.crs_s1   = i_carrier_sense;
        next_st.crs_s2   = st.crs_s1;
        next_st.col_s1   = i_collision;
        next_st.col_s2   = st.col_s1;
        next_st.col_prev = st.col_s2;

        // transmit monitor
        case (st.tx_state)
            mdsf_pkg::MDSF_TX_IDLE: begin
                if (i_tx_start) begin
                    next_st.tx_state = mdsf_pkg::MDSF_TX_EARLY;
                    next_st.slot_cnt = '0;
                    next_st.crs_seen = st.crs_s2;
                end
            end
            mdsf_pkg::MDSF_TX_EARLY: begin
                if (st.crs_s2) begin
                    next_st.crs_seen = 1'b1;
                end else if (st.crs_seen) begin
                    next_st.crs_seen = 1'b0;
                end
                if (i_tx_start) begin
                    next_st.slot_cnt = '0;
                    next_st.crs_seen = st.crs_s2;
                end else if (i_tx_end) begin
                    next_st.tx_state = mdsf_pkg::MDSF_TX_IDLE;
                end else if (slot_done) begin
                    // early collisions are normal and left to the retry logic
                    next_st.tx_state = mdsf_pkg::MDSF_TX_LATE;
                end else begin
                    next_st.slot_cnt = st.slot_cnt + `MDSF_SLOT_CNT_W'(1);
                end
            end
            mdsf_pkg::MDSF_TX_LATE: begin
                if (st.crs_s2) begin
                    next_st.crs_seen = 1'b1;
                end else if (st.crs_seen) begin
                    next_st.crs_seen = 1'b0;
                end
                if (i_tx_start) begin
                    next_st.tx_state = mdsf_pkg::MDSF_TX_EARLY;
                    next_st.slot_cnt = '0;
                    next_st.crs_seen = st.crs_s2;
                end else if (i_tx_end) begin
                    next_st.tx_state = mdsf_pkg::MDSF_TX_IDLE;
                end
            end
            default: begin
                next_st.tx_state = mdsf_pkg::MDSF_TX_IDLE;
                next_st.slot_cnt = '0;
                next_st.crs_seen = 1'b0;
            end
        endcase

        // receive stays stalled until software hands back a descriptor
        if (evt.rx_desc_empty) begin
            next_st.rx_stalled = 1'b1;
        end else if (i_rx_restart) begin
            next_st.rx_stalled = 1'b0;
        end

        // enable register
        if (i_bus.wr && sel_irq_en) begin
            next_st.irq_en = wr_ones;
        end

        // read data stand in the cycle after the strobe only
        next_st.rdata = `MDSF_WORD_RST;
        if (i_bus.rd) begin
            if (sel_status) begin
                // reserved bits 15..12 are never set in pack_word
                next_st.rdata = pack_word(flags);
            end else if (sel_irq_en) begin
                next_st.rdata = pack_word(st.irq_en);
            end
        end

        // level interrupt, registered so the pin is glitch free
        next_st.irq = |(next_flags_seen & next_st.irq_en);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st          <= '0;
            st.tx_state <= mdsf_pkg::MDSF_TX_IDLE;
            st.irq_en   <= `MDSF_IRQ_EN_RST;
            st.rdata    <= `MDSF_WORD_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata      = st.rdata;
    assign o_rx_stalled = st.rx_stalled;
    assign o_irq        = st.irq;

endmodule // mdsf_status_flags

// *** bench/mdsf_phy_model.sv ***
// phy pin model: carrier sense and collision driven on bench command
// assumes commands from the bench; both pins start low and then follow the commands
`timescale 1ns/1ps

module mdsf_phy_model (
    // clock
    input  wire logic i_clk,
    // commands
    input  wire logic i_carrier_on,
    input  wire logic i_col_on,
    // pins
    output logic      o_carrier_sense,
    output logic      o_collision
);
    initial begin
        o_carrier_sense = 1'b0;
        o_collision     = 1'b0;
    end

    // skewed off the edge: the real phy has no phase tie to the register clock
    always @(posedge i_clk) begin
        o_carrier_sense <= #2 i_carrier_on;
        o_collision     <= #2 i_col_on;
    end
endmodule // mdsf_phy_model

// *** bench/mdsf_status_flags_asserts.sv ***
// port checker for the status flag bank
// assumes bind onto mdsf_status_flags, a single clock domain
`timescale 1ns/1ps
`include "mdsf_cfg.svh"

module mdsf_status_flags_asserts (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire mdsf_pkg::mdsf_bus_req_t i_bus,
    input  wire logic [31:0]             o_rdata,
    input  wire logic                    i_rx_desc_written,
    input  wire logic                    i_rx_desc_fetched,
    input  wire logic                    i_rx_desc_owned_bit,
    input  wire logic                    i_rx_frame_busy,
    input  wire logic                    i_rx_fifo_ovf,
    input  wire logic                    i_tx_start,
    input  wire logic                    i_carrier_sense,
    input  wire logic                    o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_rd_status;
        i_bus.rd && i_bus.addr == `MDSF_STATUS_OFS;
    endsequence
    sequence s_no_rx_ev;
        !i_rx_desc_written && !i_rx_desc_fetched && !i_rx_fifo_ovf;
    endsequence
    sequence s_quiet_rd;
        s_rd_status ##0 s_no_rx_ev;
    endsequence

    chk_rsv_zero: assert property (o_rdata[15:12] == 4'h0)
        else $error("reserved status bits read nonzero");
    chk_frame_flag: assert property (
        i_rx_desc_written ##[1:2] s_rd_status |=> o_rdata[18])
        else $error("frame received flag not set");
    chk_desc_empty: assert property (
        i_rx_desc_fetched && !i_rx_desc_owned_bit ##[1:2] s_rd_status |=> o_rdata[17])
        else $error("descriptor empty flag not set");
    chk_fifo_ovf: assert property (
        i_rx_fifo_ovf && i_rx_frame_busy ##[1:2] s_rd_status |=> o_rdata[16])
        else $error("fifo overflow flag not set");
    chk_no_carrier: assert property (
        i_tx_start && !i_carrier_sense && !$past(i_carrier_sense)
        && !$past(i_carrier_sense, 2) && !$past(i_carrier_sense, 3)
        ##[1:2] s_rd_status |=> o_rdata[11])
        else $error("no carrier flag not set");
    chk_irq_mask: assert property (
        i_bus.wr && i_bus.addr == `MDSF_IRQ_EN_OFS && i_bus.wdata == 32'h0 |=> !o_irq)
        else $error("interrupt high with all enables clear");
    chk_read_clear: assert property (
        s_quiet_rd ##1 s_no_rx_ev ##1 s_quiet_rd |=> o_rdata[18:16] == 3'h0)
        else $error("rx flags survived a status read");
    chk_w1c_clear: assert property (
        i_bus.wr && i_bus.addr == `MDSF_STATUS_OFS && i_bus.wdata[18] && !i_rx_desc_written
        ##1 !i_rx_desc_written ##1 (i_bus.rd && i_bus.addr == `MDSF_STATUS_OFS
        && !i_rx_desc_written) |=> !o_rdata[18])
        else $error("write one did not clear frame flag");
endmodule // mdsf_status_flags_asserts

bind mdsf_status_flags mdsf_status_flags_asserts u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_rx_desc_written(i_rx_desc_written), .i_rx_desc_fetched(i_rx_desc_fetched),
    .i_rx_desc_owned_bit(i_rx_desc_owned_bit), .i_rx_frame_busy(i_rx_frame_busy),
    .i_rx_fifo_ovf(i_rx_fifo_ovf), .i_tx_start(i_tx_start),
    .i_carrier_sense(i_carrier_sense), .o_irq(o_irq));

// *** bench/mdsf_status_flags_test.sv ***
// register level bench for the status flag bank
// assumes the phy model on the pins and the bound port checker
`timescale 1ns/1ps
`include "mdsf_cfg.svh"

module mdsf_status_flags_test;
    logic                    i_clk;
    logic                    i_rst;
    logic                    car_on;
    logic                    col_on;
    logic                    carrier;
    logic                    collision;
    logic                    irq;
    logic                    stalled;
    logic [7:0]              ev; // written fetched owned busy ovf restart start end
    logic [31:0]             rdata;
    mdsf_pkg::mdsf_bus_req_t bus;
    int                      bad_count;
    int                      n_checks;
    int                      cyc;

    mdsf_status_flags uut (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
        .i_rx_desc_written(ev[7]), .i_rx_desc_fetched(ev[6]), .i_rx_desc_owned_bit(ev[5]),
        .i_rx_frame_busy(ev[4]), .i_rx_fifo_ovf(ev[3]), .i_rx_restart(ev[2]),
        .o_rx_stalled(stalled), .i_tx_start(ev[1]), .i_tx_end(ev[0]),
        .i_carrier_sense(carrier), .i_collision(collision), .o_irq(irq));
    mdsf_phy_model phy (.i_clk(i_clk), .i_carrier_on(car_on), .i_col_on(col_on),
        .o_carrier_sense(carrier), .o_collision(collision));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask
    // one cycle of rx/tx strobes; returns just after the edge that takes them
    task automatic pulse(input logic [7:0] v);
        @(posedge i_clk);
        ev <= v;
        @(posedge i_clk);
        ev <= 8'h00;
        #1;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        i_rst = 1'b1;
        bus = '0;
        ev = 8'h00;
        car_on = 1'b0;
        col_on = 1'b0;
        cyc = 0;
        wt(5);
        i_rst <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h0007_0E00);
        rd(8'h04, 32'h0007_0E00);
        pulse(8'h80);
        chk(irq, 1);
        rd(8'h00, 32'h0004_0000);
        chk(irq, 0);
        rd(8'h00, 32'h0);
        pulse(8'h40);
        chk(stalled, 1);
        pulse(8'h60);
        rd(8'h00, 32'h0002_0000);
        pulse(8'h04);
        chk(stalled, 0);
        pulse(8'h08);
        rd(8'h00, 32'h0);
        pulse(8'h18);
        rd(8'h00, 32'h0001_0000);
        pulse(8'h80);
        wr(8'h00, 32'h0004_0000);
        rd(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        pulse(8'h80);
        chk(irq, 0);
        rd(8'h00, 32'h0004_0000);
        wr(8'h04, 32'h0007_0E00);
        pulse(8'h02);
        rd(8'h00, 32'h0000_0800);
        pulse(8'h01);
        car_on <= 1'b1;
        wt(4);
        pulse(8'h02);
        wt(5);
        car_on <= 1'b0;
        wt(5);
        pulse(8'h01);
        rd(8'h00, 32'h0000_0400);
        car_on <= 1'b1;
        wt(4);
        for (int late = 0; late < 2; late++) begin
            pulse(8'h02);
            wt(late ? 700 : 100);
            col_on <= 1'b1;
            wt(4);
            col_on <= 1'b0;
            wt(4);
            pulse(8'h01);
            rd(8'h00, late ? 32'h0000_0200 : 32'h0);
        end
        print_verdict();
    end
endmodule // mdsf_status_flags_test
